// ---- rtl/ccds_pkg.sv ----
package ccds_pkg;
    localparam int MCLK_HZ = 20_000_000;
    localparam int MCLK_NS = 1_000_000_000 / MCLK_HZ;
    // standard-sensor pixel rate is the master clock over eight
    localparam int PIX_DIV = 8;
    localparam int ALT_DIV_FAST = 16;
    localparam int ALT_DIV_SLOW = 32;
    localparam int DIV_W = 6;
    localparam int SER_HALF_NS = 50;
    localparam int SER_HALF_RAW = (SER_HALF_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int SER_HALF_CYC = (SER_HALF_RAW < 1) ? 1 : SER_HALF_RAW;
    localparam int UNIT_MS = 10;
    localparam int INT_MAX_MS = 10_000;
    localparam int INT_MULT_MAX = INT_MAX_MS / UNIT_MS;
    localparam int INT_MULT_W = 10;
    localparam int PIX_W = 12;
    localparam int SW_W = 3;
    localparam int CNT_W = 13;
    localparam int ADDR_W = 3;
    localparam int LDATA_W = 8;
    localparam int SER_W = 16;
    localparam int LOAD_N = 8;
    localparam int FIFO_W = PIX_W + 2;
    localparam int FIFO_D = 16;
    localparam logic [CNT_W-1:0] LINE_LEN [8] = '{13'h0200, 13'h0300, 13'h0400, 13'h0600,
                                                 13'h0800, 13'h0C00, 13'h1000, 13'h0010};
    localparam logic [CNT_W-1:0] FRAME_LEN [8] = '{13'h0200, 13'h0200, 13'h0400, 13'h0400,
                                                  13'h0800, 13'h0800, 13'h1000, 13'h0008};
    // converter word: write bit, address, four fill bits, eight data bits
    localparam logic [SER_W-1:0] LOAD_WORDS [LOAD_N] = '{16'h00D8, 16'h1042, 16'h2000, 16'h3000,
                                                        16'h4000, 16'h5000, 16'h6000, 16'h7000};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FLUSH = 3'b001,
        ST_INTEG = 3'b010,
        ST_VSHIFT = 3'b011,
        ST_HREAD = 3'b100
    } ccds_state_t;

    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_SHIFT = 2'b01,
        LD_GAP = 2'b10
    } ccds_ld_state_t;

    function automatic logic [1:0] bin_factor(input logic b);
        bin_factor = b ? 2'h2 : 2'h1;
    endfunction : bin_factor

    function automatic logic [SER_W-1:0] make_word(input logic [ADDR_W-1:0] a, input logic [LDATA_W-1:0] d);
        make_word = {1'b0, a, 3'h0, 1'b0, d};
    endfunction : make_word
endpackage : ccds_pkg

// ---- rtl/ccds_stream_if.sv ----
`timescale 1ns/1ps
interface ccds_stream_if #(parameter int W = 14);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ccds_stream_if

// ---- rtl/ccds_fifo.sv ----
`timescale 1ns/1ps
module ccds_fifo #(
    parameter int W = 14,
    parameter int D = 16
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    ccds_stream_if.snk wr,
    ccds_stream_if.src rd
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] FULL = CW'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    wire do_wr = wr.valid && wr.ready;
    wire do_rd = rd.valid && rd.ready;

    assign wr.ready = (cnt != FULL);
    assign rd.valid = (cnt != '0);
    assign rd.data = mem[rp];

    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem[wp] <= wr.data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (do_wr) begin
                wp <= (wp == LAST) ? '0 : wp + 1'b1;
            end
            if (do_rd) begin
                rp <= (rp == LAST) ? '0 : rp + 1'b1;
            end
            cnt <= cnt + CW'(do_wr) - CW'(do_rd);
        end
    end

    AST_FIFO_FULL_HOLD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (cnt == FULL) && !do_rd |=> (cnt == FULL) && !wr.ready)
        else $error("fifo lost its full state");
    AST_FIFO_COUNT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        do_wr && !do_rd |=> cnt == $past(cnt) + 1'b1)
        else $error("fifo count did not follow a write");
    COV_FIFO_FULL: cover property (@(posedge i_clk) disable iff (!i_arst_n) cnt == FULL);
endmodule : ccds_fifo

// ---- rtl/ccds_sequencer.sv ----
`timescale 1ns/1ps
module ccds_sequencer
    import ccds_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    input wire logic I_ACQ_N,
    input wire logic I_MODE_STILL,
    input wire logic I_UNIT_TICK,
    input wire logic I_SER_EXT,
    input wire logic I_GRAB_READY,
    input wire logic I_ALT_SENSOR,
    input wire logic [ccds_pkg::SW_W-1:0] I_SENSOR_SEL,
    input wire logic [ccds_pkg::SW_W-1:0] I_BIN_SEL,
    input wire logic [ccds_pkg::INT_MULT_W-1:0] I_INT_MULT,
    input wire logic [ccds_pkg::ADDR_W-1:0] I_LOAD_ADDR,
    input wire logic [ccds_pkg::LDATA_W-1:0] I_LOAD_DATA,
    input wire logic [ccds_pkg::PIX_W-1:0] I_ADC_DATA,
    output logic [ccds_pkg::PIX_W-1:0] O_VIDEO,
    output logic O_FRAME_SYNC,
    output logic O_LINE_SYNC,
    output logic O_PIXEL_SYNC,
    output logic O_INTEGRATION_SYNC,
    output logic O_FRAME_ACTIVE,
    output logic O_H1,
    output logic O_H2,
    output logic O_V1,
    output logic O_V2,
    output logic O_CDS_RST_SAMPLE,
    output logic O_CDS_VID_SAMPLE,
    output logic O_ADC_CLK,
    output logic O_SCLK,
    output logic O_SDATA,
    output logic O_SLOAD_N,
    output logic O_SER_OE_N,
    output logic O_INIT_DONE
);
    import ccds_pkg::*;

    localparam int SYN_W = 6 + 2 * SW_W + INT_MULT_W + ADDR_W + LDATA_W + PIX_W;
    localparam logic [DIV_W-1:0] DIV_STD = DIV_W'(PIX_DIV);
    localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(ALT_DIV_FAST);
    localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(ALT_DIV_SLOW);
    localparam logic [INT_MULT_W-1:0] MULT_MAX = INT_MULT_W'(INT_MULT_MAX);
    localparam logic [3:0] LD_LAST = 4'(LOAD_N);
    localparam logic [4:0] BIT_LAST = 5'(SER_W - 1);
    localparam logic [3:0] HALF_LAST = 4'(SER_HALF_CYC - 1);
    // request idles high; still mode and external serial ownership are the safe levels until pins are seen
    localparam logic [SYN_W-1:0] SYN_RST = {6'h34, {(SYN_W - 6){1'b0}}};

    // two-stage capture of every input pin except clock and reset; only stage two is read
    logic [SYN_W-1:0] syn1;
    logic [SYN_W-1:0] syn2;
    logic acq_n, mode_still, tick, ser_ext, grab_ready, alt_sensor;
    logic [SW_W-1:0] sensor_sel, bin_sel;
    logic [INT_MULT_W-1:0] int_mult;
    logic [ADDR_W-1:0] load_addr;
    logic [LDATA_W-1:0] load_data;
    logic [PIX_W-1:0] adc_data;
    assign {acq_n, mode_still, tick, ser_ext, grab_ready, alt_sensor, sensor_sel, bin_sel,
            int_mult, load_addr, load_data, adc_data} = syn2;

    logic acq_d;
    logic tick_d;
    wire acq_fall = acq_d && !acq_n;
    wire tick_rise = !tick_d && tick;

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            syn1 <= SYN_RST;
            syn2 <= SYN_RST;
            acq_d <= 1'b1;
            tick_d <= 1'b0;
        end else begin
            syn1 <= {I_ACQ_N, I_MODE_STILL, I_UNIT_TICK, I_SER_EXT, I_GRAB_READY, I_ALT_SENSOR, I_SENSOR_SEL,
                     I_BIN_SEL, I_INT_MULT, I_LOAD_ADDR, I_LOAD_DATA, I_ADC_DATA};
            syn2 <= syn1;
            acq_d <= acq_n;
            tick_d <= tick;
        end
    end

    // pixel divider; the alternate sensor has no binning
    wire [DIV_W-1:0] div_sel = !alt_sensor ? DIV_STD :
                               (bin_sel == '0) ? DIV_SLOW : DIV_FAST;
    logic [DIV_W-1:0] div_cnt;
    wire pix_en = (div_cnt >= div_sel - 1'b1);
    wire first_half = (div_cnt < (div_sel >> 1));
    wire samp_rst = (div_cnt == (div_sel >> 2));
    wire samp_vid = (div_cnt == (div_sel >> 1) + (div_sel >> 2));

    ccds_stream_if #(.W(FIFO_W)) push ();
    ccds_stream_if #(.W(FIFO_W)) pop ();

    ccds_state_t state;
    ccds_state_t next_state;
    logic [1:0] sub_cnt;
    logic [CNT_W-1:0] col_cnt;
    logic [CNT_W-1:0] row_cnt;
    logic [INT_MULT_W-1:0] int_cnt;

    wire [CNT_W-1:0] line_len = LINE_LEN[sensor_sel];
    wire [CNT_W-1:0] frame_len = FRAME_LEN[sensor_sel];
    wire [1:0] hb = alt_sensor ? 2'h1 : bin_factor(bin_sel[0]);
    wire [1:0] vb = alt_sensor ? 2'h1 : bin_factor(bin_sel[1]);
    wire [INT_MULT_W-1:0] mult_eff = (int_mult == '0) ? INT_MULT_W'(1) :
                                     (int_mult > MULT_MAX) ? MULT_MAX : int_mult;
    wire h_last = (sub_cnt == hb - 1'b1);
    wire v_last = (sub_cnt == vb - 1'b1);
    wire col_last = (col_cnt == line_len - 1'b1);
    wire row_last = (row_cnt == frame_len - 1'b1);
    wire int_last = (int_cnt == mult_eff - 1'b1);
    wire in_read = (state == ST_VSHIFT) || (state == ST_HREAD);
    wire in_vert = (state == ST_FLUSH) || (state == ST_VSHIFT);
    // a full buffer freezes the readout instead of dropping pixels
    wire adv = pix_en && ((state != ST_HREAD) || push.ready);
    wire pix_done = adv && (state == ST_HREAD) && h_last;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (!mode_still) begin
                    next_state = ST_INTEG;
                end else if (acq_fall) begin
                    next_state = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (adv && v_last && row_last) begin
                    next_state = ST_INTEG;
                end
            end
            ST_INTEG: begin
                if (tick_rise && int_last) begin
                    next_state = ST_VSHIFT;
                end
            end
            ST_VSHIFT: begin
                if (adv && v_last) begin
                    next_state = ST_HREAD;
                end
            end
            ST_HREAD: begin
                if (pix_done && col_last) begin
                    next_state = !row_last ? ST_VSHIFT : mode_still ? ST_IDLE : ST_INTEG;
                end
            end
        endcase
    end

    wire st_chg = (next_state != state);

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            div_cnt <= '0;
            state <= ST_IDLE;
            sub_cnt <= '0;
            col_cnt <= '0;
            row_cnt <= '0;
            int_cnt <= '0;
        end else begin
            div_cnt <= pix_en ? '0 : div_cnt + 1'b1;
            state <= next_state;
            if (st_chg) begin
                sub_cnt <= '0;
            end else if (adv && state != ST_IDLE && state != ST_INTEG) begin
                sub_cnt <= ((in_vert && v_last) || (state == ST_HREAD && h_last)) ? 2'h0 : sub_cnt + 1'b1;
            end
            if (pix_done) begin
                col_cnt <= col_last ? '0 : col_cnt + 1'b1;
            end
            if (st_chg && (next_state == ST_FLUSH || next_state == ST_INTEG)) begin
                row_cnt <= '0;
            end else if ((state == ST_FLUSH && adv && v_last) || (pix_done && col_last)) begin
                row_cnt <= row_cnt + 1'b1;
            end
            if (st_chg) begin
                int_cnt <= '0;
            end else if (state == ST_INTEG && tick_rise) begin
                int_cnt <= int_cnt + 1'b1;
            end
        end
    end

    // sensor and converter timing, all from flops
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            {O_V1, O_V2, O_H1, O_H2, O_CDS_RST_SAMPLE, O_CDS_VID_SAMPLE, O_ADC_CLK} <= '0;
            O_INTEGRATION_SYNC <= 1'b0;
            O_FRAME_ACTIVE <= 1'b0;
        end else begin
            O_V1 <= in_vert && first_half;
            O_V2 <= in_vert && !first_half;
            O_H1 <= (state == ST_HREAD) && first_half;
            O_H2 <= (state == ST_HREAD) && !first_half;
            O_CDS_RST_SAMPLE <= (state == ST_HREAD) && samp_rst;
            O_CDS_VID_SAMPLE <= (state == ST_HREAD) && samp_vid;
            O_ADC_CLK <= first_half;
            O_INTEGRATION_SYNC <= (next_state == ST_INTEG);
            O_FRAME_ACTIVE <= (next_state == ST_VSHIFT) || (next_state == ST_HREAD);
        end
    end

    // pixel words carry frame-start and line-start marks
    assign push.valid = pix_done;
    assign push.data = {(col_cnt == '0) && (row_cnt == '0), col_cnt == '0, adc_data};
    assign pop.ready = grab_ready;

    ccds_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .i_clk(I_MCLK),
        .i_arst_n(I_ARST_N),
        .wr(push),
        .rd(pop)
    );

    wire do_pop = pop.valid && pop.ready;

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_VIDEO <= '0;
            {O_FRAME_SYNC, O_LINE_SYNC, O_PIXEL_SYNC} <= '0;
        end else begin
            if (do_pop) begin
                O_VIDEO <= pop.data[PIX_W-1:0];
            end
            O_FRAME_SYNC <= do_pop && pop.data[PIX_W+1];
            O_LINE_SYNC <= do_pop && pop.data[PIX_W];
            O_PIXEL_SYNC <= do_pop;
        end
    end

    // converter loader: defaults first, then switch words on capture
    ccds_ld_state_t ld_state;
    logic [3:0] ld_idx;
    logic user_pend;
    logic [SER_W-1:0] shreg;
    logic [4:0] bit_cnt;
    logic [3:0] half_cnt;
    wire init_pend = (ld_idx != LD_LAST);
    wire ld_take = (ld_state == LD_IDLE) && !ser_ext && (init_pend || user_pend);
    wire [SER_W-1:0] ld_word = init_pend ? LOAD_WORDS[ld_idx[2:0]] : make_word(load_addr, load_data);
    wire half_tick = (half_cnt == HALF_LAST);

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ld_state <= LD_IDLE;
            ld_idx <= '0;
            user_pend <= 1'b0;
            shreg <= '0;
            bit_cnt <= '0;
            half_cnt <= '0;
            {O_SCLK, O_SDATA} <= '0;
            O_SLOAD_N <= 1'b1;
            O_SER_OE_N <= 1'b1;
            O_INIT_DONE <= 1'b0;
        end else begin
            // a capture in the cycle its earlier request is taken stays pending
            user_pend <= acq_fall || (user_pend && !(ld_take && !init_pend));
            O_SER_OE_N <= ser_ext && (ld_state == LD_IDLE);
            O_INIT_DONE <= !init_pend;
            half_cnt <= (ld_state == LD_IDLE || half_tick) ? 4'h0 : half_cnt + 1'b1;
            unique case (ld_state)
                LD_IDLE: begin
                    if (ld_take) begin
                        ld_state <= LD_SHIFT;
                        ld_idx <= init_pend ? ld_idx + 1'b1 : ld_idx;
                        shreg <= ld_word;
                        O_SDATA <= ld_word[SER_W-1];
                        O_SLOAD_N <= 1'b0;
                        bit_cnt <= '0;
                    end
                end
                LD_SHIFT: begin
                    if (half_tick) begin
                        O_SCLK <= !O_SCLK;
                        if (O_SCLK) begin
                            shreg <= {shreg[SER_W-2:0], 1'b0};
                            O_SDATA <= shreg[SER_W-2];
                            bit_cnt <= bit_cnt + 1'b1;
                            if (bit_cnt == BIT_LAST) begin
                                ld_state <= LD_GAP;
                                O_SLOAD_N <= 1'b1;
                            end
                        end
                    end
                end
                LD_GAP: begin
                    if (half_tick) begin
                        ld_state <= LD_IDLE;
                    end
                end
                default: ld_state <= LD_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);

    AST_STD_DIV: assert property (pix_en && !alt_sensor |=> (!pix_en) [*7])
        else $error("standard pixel enable spacing wrong");
    AST_ALT_FAST: assert property (pix_en && alt_sensor && bin_sel != '0 && $stable(div_sel)
        |-> div_cnt == DIV_FAST - 1'b1)
        else $error("alternate fast pixel period wrong");
    AST_ALT_SLOW: assert property (pix_en && alt_sensor && bin_sel == '0 && $stable(div_sel)
        |-> div_cnt == DIV_SLOW - 1'b1)
        else $error("slow pixel period not chosen at position zero");
    AST_STILL_START: assert property (state == ST_IDLE && mode_still && acq_fall |=> state == ST_FLUSH)
        else $error("still request did not start a flush");
    AST_FLUSH_STILL_ONLY: assert property (state != ST_FLUSH && next_state == ST_FLUSH |-> mode_still)
        else $error("flush entered outside still mode");
    AST_INT_SYNC: assert property (O_INTEGRATION_SYNC == (state == ST_INTEG))
        else $error("integration sync not aligned to integration");
    AST_INT_END: assert property (state == ST_INTEG && tick_rise && int_last |=> state == ST_VSHIFT
        ##1 !O_INTEGRATION_SYNC)
        else $error("integration did not end at the selected count");
    AST_LINE_LEN: assert property (pix_done && col_last |=> col_cnt == '0)
        else $error("line length counter did not wrap");
    AST_CLK_EXCL: assert property (!(O_H1 && O_H2) && !(O_V1 && O_V2))
        else $error("overlapping clock phases");
    AST_STALL: assert property (state == ST_HREAD && pix_en && !push.ready |=> $stable(col_cnt))
        else $error("readout advanced into a full buffer");
    AST_USER_KEEP: assert property (acq_fall |=> user_pend)
        else $error("capture request lost by the loader");
    AST_LOAD_FRAME: assert property ($fell(O_SLOAD_N) |-> ld_state == LD_SHIFT ##1 !O_SLOAD_N [*2])
        else $error("serial word framing broken");

    COV_STILL_FRAME: cover property (state == ST_HREAD && next_state == ST_IDLE);
    COV_FREE_LOOP: cover property (state == ST_HREAD && next_state == ST_INTEG);
    COV_USER_LOAD: cover property (ld_take && !init_pend);
endmodule : ccds_sequencer

// ---- tb/ccds_partner.sv ----
`timescale 1ns/1ps
module ccds_partner (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_stall,
    input wire logic [11:0] i_adc_value,
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_sload_n,
    output logic o_grab_ready,
    output logic [11:0] o_adc_data,
    output logic [15:0] o_word,
    output logic [4:0] o_nbits,
    output logic o_word_stb
);
    // converter keeps one 8-bit gain or offset code per address
    logic [7:0] regs [8];
    logic [15:0] sh;
    logic [4:0] n;
    logic sclk_q, load_q;
    always @(negedge i_clk) begin
        o_grab_ready <= !i_stall;
        o_adc_data <= i_adc_value;
    end
    // bits are taken on the rising serial clock only, never on a level
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            n <= 5'h00;
            sclk_q <= 1'b0;
            load_q <= 1'b1;
            o_word_stb <= 1'b0;
        end else begin
            sclk_q <= i_sclk;
            load_q <= i_sload_n;
            o_word_stb <= i_sload_n && !load_q;
            if (!i_sload_n && i_sclk && !sclk_q) begin
                sh <= {sh[14:0], i_sdata};
                n <= n + 5'h01;
            end
            if (i_sload_n && !load_q) begin
                o_word <= sh;
                o_nbits <= n;
                n <= 5'h00;
                regs[sh[14:12]] <= sh[7:0];
            end
        end
    end
endmodule : ccds_partner

// ---- tb/ccds_sequencer_tb.sv ----
`timescale 1ns/1ps
module ccds_sequencer_tb;
    import ccds_pkg::*;
    logic clk = 0, arst_n = 0, acq_n = 1, still = 1, tick = 0, ser_ext = 1, stall = 1, hold = 0, alt = 0;
    logic [SW_W-1:0] sen_sel = 3'h7, bin_sel = 3'h0;
    logic [INT_MULT_W-1:0] mult = 10'h001;
    logic [ADDR_W-1:0] ld_addr = 3'h0;
    logic [LDATA_W-1:0] ld_data = 8'h00;
    logic [PIX_W-1:0] adc_v = 12'h000, adc_d, video;
    logic grab_ready, wstb, fs, ls, ps, isync, fa, v1, aclk, sclk, sdata, sload_n, oe_n, done;
    logic [15:0] word;
    logic [4:0] nbits;
    int error_cnt = 0, check_count = 0, seed = 66908, nfs = 0, nls = 0, p;
    int px = LINE_LEN[7] * FRAME_LEN[7];
    logic [15:0] wq [$];
    logic [PIX_W-1:0] vq [$];
    ccds_sequencer ccds_sequencer_i (.I_MCLK(clk), .I_ARST_N(arst_n), .I_ACQ_N(acq_n), .I_MODE_STILL(still),
        .I_UNIT_TICK(tick), .I_SER_EXT(ser_ext), .I_GRAB_READY(grab_ready), .I_ALT_SENSOR(alt),
        .I_SENSOR_SEL(sen_sel), .I_BIN_SEL(bin_sel), .I_INT_MULT(mult), .I_LOAD_ADDR(ld_addr),
        .I_LOAD_DATA(ld_data), .I_ADC_DATA(adc_d), .O_VIDEO(video), .O_FRAME_SYNC(fs), .O_LINE_SYNC(ls),
        .O_PIXEL_SYNC(ps), .O_INTEGRATION_SYNC(isync), .O_FRAME_ACTIVE(fa), .O_H1(), .O_H2(), .O_V1(v1),
        .O_V2(), .O_CDS_RST_SAMPLE(), .O_CDS_VID_SAMPLE(), .O_ADC_CLK(aclk), .O_SCLK(sclk),
        .O_SDATA(sdata), .O_SLOAD_N(sload_n), .O_SER_OE_N(oe_n), .O_INIT_DONE(done));
    ccds_partner ccds_partner_i (.i_clk(clk), .i_arst_n(arst_n), .i_stall(stall), .i_adc_value(adc_v),
        .i_sclk(sclk), .i_sdata(sdata), .i_sload_n(sload_n), .o_grab_ready(grab_ready),
        .o_adc_data(adc_d), .o_word(word), .o_nbits(nbits), .o_word_stb(wstb));
    initial forever #25 clk = ~clk;
    // unit tick shortened to 100 cycles so long integrations stay cheap
    initial forever begin
        repeat (50) @(negedge clk);
        tick <= ~tick;
    end
    always @(negedge clk) stall <= hold || (($random(seed) & 3) == 0);
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    always @(negedge clk) begin
        if (wstb === 1'b1) begin
            check("word_noted", 16'h0001, {15'h0000, wq.size() != 0});
            if (wq.size() != 0) check("serial_word", wq.pop_front(), word);
            check("serial_bits", 16'h0010, {11'h000, nbits});
        end
        if (ps === 1'b1) begin
            check("pixel_noted", 16'h0001, {15'h0000, vq.size() != 0});
            if (vq.size() != 0) check("video", {4'h0, vq.pop_front()}, {4'h0, video});
            nfs += (fs === 1'b1);
            nls += (ls === 1'b1);
        end
    end
    task automatic wait_ev(input int k, input int lim);
        int c;
        logic hit;
        for (c = 0; c <= lim; c++) begin
            case (k)
                0: hit = done === 1'b1;
                1: hit = isync === 1'b1;
                default: hit = wq.size() == 0 && vq.size() == 0;
            endcase
            if (hit) return;
            @(negedge clk);
        end
        error_cnt++;
        $display("BAD wait %0d expected event seen timeout", k);
        print_verdict();
    endtask : wait_ev
    task automatic pix_period(output int p);
        int c;
        for (c = 0; c < 80 && aclk !== 1'b0; c++) @(negedge clk);
        for (c = 0; c < 80 && aclk !== 1'b1; c++) @(negedge clk);
        for (p = 0; p < 80 && aclk === 1'b1; p++) @(negedge clk);
        for (c = p; c < 160 && aclk === 1'b0; c++) @(negedge clk);
        p = c;
    endtask : pix_period
    task automatic pulse_acq;
        wq.push_back({1'b0, ld_addr, 3'h0, 1'b0, ld_data});
        acq_n <= 1'b0;
        repeat (4) @(negedge clk);
        acq_n <= 1'b1;
    endtask : pulse_acq
    task automatic acquire(input logic st, input int m, input int nfr, input logic hs);
        int c, w, fl;
        c = (m == 0) ? 1 : m;
        still <= st;
        hold <= hs;
        mult <= m[INT_MULT_W-1:0];
        adc_v <= 12'($random(seed));
        ld_addr <= 3'($random(seed));
        ld_data <= 8'($random(seed));
        nfs = 0;
        nls = 0;
        @(negedge clk);
        repeat (nfr * px) vq.push_back(adc_v);
        if (st) pulse_acq();
        for (fl = 0, w = 0; w < 400 && isync !== 1'b1; w++) begin
            fl += (v1 === 1'b1);
            @(negedge clk);
        end
        check("flush_seen", {15'h0000, st}, {15'h0000, fl > 0});
        wait_ev(1, 10);
        for (w = 0; w < 12000 && isync === 1'b1; w++) @(negedge clk);
        check("integ_len", 16'h0001, {15'h0000, w >= (c - 1) * 100 - 4 && w <= c * 100 + 8});
        check("frame_active", 16'h0001, {15'h0000, fa});
        if (hs) begin
            repeat (400) @(negedge clk);
            check("fifo_hold", 16'(px), 16'(vq.size()));
            hold <= 1'b0;
        end
        for (w = 0; !st && w < 8000 && nfs < nfr; w++) @(negedge clk);
        still <= 1'b1;
        wait_ev(3, 8000);
        check("frames", 16'(nfr), 16'(nfs));
        check("lines", 16'(nfr * FRAME_LEN[7]), 16'(nls));
        repeat (400) @(negedge clk);
        $display("test acquire mode %0d done", st);
    endtask : acquire
    initial begin
        repeat (12) @(negedge clk);
        check("reset_load_n", 16'h0001, {15'h0000, sload_n});
        check("reset_oe_n", 16'h0001, {15'h0000, oe_n});
        arst_n <= 1'b1;
        repeat (60) @(negedge clk);
        check("ext_owner_oe_n", 16'h0001, {15'h0000, oe_n});
        for (int i = 0; i < LOAD_N; i++) wq.push_back(LOAD_WORDS[i]);
        ser_ext <= 1'b0;
        wait_ev(0, 2000);
        wait_ev(3, 100);
        $display("test default load done");
        for (int k = 0; k < 3; k++) begin
            alt <= k > 0;
            bin_sel <= (k == 2) ? 3'h5 : 3'h0;
            repeat (80) @(negedge clk);
            pix_period(p);
            check("pixel_div", 16'(k == 0 ? PIX_DIV : k == 1 ? ALT_DIV_SLOW : ALT_DIV_FAST), 16'(p));
        end
        alt <= 1'b0;
        bin_sel <= 3'h0;
        $display("test pixel divider done");
        acquire(1'b1, 2, 1, 1'b1);
        acquire(1'b0, 0, 2, 1'b0);
        acquire(1'b1, 1, 1, 1'b0);
        // a long integration keeps the reset below inside the integration_sync phase
        mult <= 10'h005;
        pulse_acq();
        wait_ev(1, 400);
        repeat (50) @(negedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        check("reset_integ", 16'h0000, {15'h0000, isync});
        check("reset_done", 16'h0000, {15'h0000, done});
        arst_n <= 1'b1;
        for (int i = 0; i < LOAD_N; i++) wq.push_back(LOAD_WORDS[i]);
        wait_ev(0, 2000);
        wait_ev(3, 100);
        repeat (300) @(negedge clk);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : ccds_sequencer_tb
